// ### src/pes_error_status.sv
/*
 * Partition error status block: captures error events into separate Secure
 * and Non-secure status registers and drives one error interrupt per state.
 * Assumes a simple 64-bit register port, one access per cycle, and error
 * events from the surrounding partitioning and monitoring checks.
 */
`timescale 1ns/100ps
module pes_error_status
	import pes_pkg::*;
#(
	parameter bit EXTENDED_STATUS = 1'b1,
	parameter bit INSTANCE_SELECT = 1'b1,
	parameter bit ADDED_FEATURES  = 1'b1
)
(
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire pes_access_t reg_acc,
	input  wire pes_event_t  err_evt,
	output logic [63:0]      reg_rdata,
	output logic             reg_rvalid,
	output logic             irq_secure,
	output logic             irq_nonsecure
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (!EXTENDED_STATUS && INSTANCE_SELECT && ADDED_FEATURES)
	begin : g_chk
		$error("Instance selector needs the extended status layout");
	end

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Code is defined for the layout in use
	function automatic logic code_defined(input logic [3:0] c);
		logic [3:0] last;
		last = EXTENDED_STATUS ? PES_EC_LAST_EXTENDED : PES_EC_LAST_BASIC;
		return (c != PES_EC_NONE) && (c <= last);
	endfunction

	// Field captures for one code: {instance, group, index}
	function automatic logic [2:0] code_caps(input logic [3:0] c);
		logic [2:0] caps;
		caps = 3'h0;
		case (c)
			PES_EC_PART_SEL:     caps = 3'h5;
			PES_EC_REQ_PARTITION_ID:   caps = 3'h3;
			PES_EC_MON_CFG_ID:   caps = 3'h7;
			PES_EC_REQ_PMG:      caps = 3'h3;
			PES_EC_MON_RANGE:    caps = 3'h5;
			PES_EC_INT_PARTITION_ID:   caps = 3'h1;
			PES_EC_UNEXP_INTERN: caps = 3'h1;
			PES_EC_PS_NO_RIS:    caps = 3'h5;
			PES_EC_PS_NO_CTRL:   caps = 3'h5;
			PES_EC_MS_NO_RIS:    caps = 3'h5;
			PES_EC_MS_NO_MON:    caps = 3'h5;
			default:             caps = 3'h0;
		endcase
		return caps;
	endfunction

	// Instance field kept for this code
	function automatic logic ris_kept(input logic [3:0] c);
		logic gated;
		gated = (c == PES_EC_PART_SEL) || (c == PES_EC_MON_CFG_ID) || (c == PES_EC_MON_RANGE);
		if (!(EXTENDED_STATUS && INSTANCE_SELECT))
		begin
			return 1'b0;
		end
		return gated ? ADDED_FEATURES : 1'b1;
	endfunction

	// Status word as software sees it
	function automatic logic [63:0] pack_status(input pes_status_t s);
		logic [63:0] w;
		w = 64'h0000_0000_0000_0000;
		w[PES_OVR_BIT] = s.ovr;
		w[PES_CODE_MSB:PES_CODE_LSB] = s.code;
		w[PES_PMG_MSB:PES_PMG_LSB] = s.perf_monitor_group;
		w[PES_IDX_MSB:PES_IDX_LSB] = s.index;
		if (EXTENDED_STATUS && INSTANCE_SELECT)
		begin
			w[PES_RIS_MSB:PES_RIS_LSB] = s.resource_instance_selector;
		end
		return w;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0]  irq_en;
		logic        rd_ctl;
		logic        rd_sts;
		logic [1:0]  rd_ien;
		logic        rvalid;
		logic [1:0]  irq;
	} pes_state_t;

	pes_state_t  st;
	pes_state_t  next_st;
	pes_status_t cur [2];
	pes_status_t wr_data [2];
	pes_status_t bank_rd;
	logic [1:0]  wr_en;
	logic [2:0]  caps;
	logic        hit_sts;
	logic        hit_ctl;
	logic        sel;
	logic        evt_ok;

	pes_status_bank u_bank
	(
		.core_clk (core_clk),
		.rstn     (rstn),
		.wr_en    (wr_en),
		.wr_data  (wr_data),
		.rd_sel   (reg_acc.secure),
		.rd_data  (bank_rd),
		.cur      (cur)
	);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	always_comb
	begin
		hit_sts = 1'b0;
		hit_ctl = 1'b0;
		if (reg_acc.valid && (reg_acc.offset == PES_OFS_STATUS))
		begin
			hit_sts = 1'b1;
		end
		else if (reg_acc.valid && (reg_acc.offset == PES_OFS_CONTROL))
		begin
			hit_ctl = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Status update: software write, then error capture on top
	// ----------------------------------------------------------------
	always_comb
	begin
		sel    = err_evt.secure;
		caps   = code_caps(err_evt.code);
		evt_ok = err_evt.valid && code_defined(err_evt.code);
		for (int i = 0; i < 2; i++)
		begin
			wr_data[i] = cur[i];
			wr_en[i]   = 1'b0;
			if (hit_sts && reg_acc.write && (reg_acc.secure == i[0]))
			begin
				wr_en[i]          = 1'b1;
				wr_data[i].ovr    = reg_acc.wdata[PES_OVR_BIT];
				wr_data[i].code   = reg_acc.wdata[PES_CODE_MSB:PES_CODE_LSB];
				wr_data[i].perf_monitor_group    = reg_acc.wdata[PES_PMG_MSB:PES_PMG_LSB];
				wr_data[i].index  = reg_acc.wdata[PES_IDX_MSB:PES_IDX_LSB];
				wr_data[i].resource_instance_selector    = (EXTENDED_STATUS && INSTANCE_SELECT) ?
					reg_acc.wdata[PES_RIS_MSB:PES_RIS_LSB] : 4'h0;
			end
			if (evt_ok && (sel == i[0]))
			begin
				wr_en[i] = 1'b1;
				// overwritten from old code; code nonzero here
				wr_data[i].ovr   = (cur[i].code != PES_EC_NONE) || (cur[i].ovr && 1'b0);
				wr_data[i].code  = err_evt.code;
				wr_data[i].perf_monitor_group   = caps[1] ? err_evt.perf_monitor_group : 8'h00;
				wr_data[i].index = caps[0] ? err_evt.index : 16'h0000;
				wr_data[i].resource_instance_selector   = (caps[2] && ris_kept(err_evt.code)) ? err_evt.resource_instance_selector : 4'h0;
			end
		end
	end

	// recorded errors feed the interrupt level below

	// ----------------------------------------------------------------
	// Control, read path and interrupt
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st        = st;
		next_st.rvalid = reg_acc.valid && !reg_acc.write;
		next_st.rd_sts = hit_sts;
		next_st.rd_ctl = hit_ctl;
		next_st.rd_ien = st.irq_en;
		if (hit_ctl && reg_acc.write)
		begin
			next_st.irq_en[reg_acc.secure] = reg_acc.wdata[PES_IEN_BIT];
		end
		if (hit_ctl)
		begin
			next_st.rd_ien[0] = reg_acc.secure ? 1'b0 : st.irq_en[reg_acc.secure];
			next_st.rd_ien[1] = st.irq_en[reg_acc.secure];
		end
		// gated by enable; level on nonzero code
		for (int i = 0; i < 2; i++)
		begin
			next_st.irq[i] = next_st.irq_en[i] && (wr_data[i].code != PES_EC_NONE);
		end
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// reads answer one cycle later, never stalled
	always_comb
	begin
		reg_rdata = 64'h0000_0000_0000_0000;
		if (st.rd_sts)
		begin
			reg_rdata = pack_status(bank_rd);
		end
		else if (st.rd_ctl)
		begin
			reg_rdata[PES_IEN_BIT] = st.rd_ien[1];
		end
	end

	assign reg_rvalid    = st.rvalid;
	assign irq_nonsecure = st.irq[0];
	assign irq_secure    = st.irq[1];

endmodule

// ### pkg/pes_pkg.sv
/*
 * Package for the partition error status block: register offsets, status field
 * layout, error codes and the packed carriers shared by the block and its memory.
 * Assumes a 64-bit register port and single clock.
 */
package pes_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] PES_OFS_CONTROL = 12'h0F0;
	localparam logic [11:0] PES_OFS_STATUS  = 12'h0F8;

	// ----------------------------------------------------------------
	// Status field positions
	// ----------------------------------------------------------------
	localparam int PES_RIS_LSB  = 32;
	localparam int PES_RIS_MSB  = 35;
	localparam int PES_OVR_BIT  = 31;
	localparam int PES_CODE_LSB = 24;
	localparam int PES_CODE_MSB = 27;
	localparam int PES_PMG_LSB  = 16;
	localparam int PES_PMG_MSB  = 23;
	localparam int PES_IDX_LSB  = 0;
	localparam int PES_IDX_MSB  = 15;
	localparam int PES_IEN_BIT  = 0;

	localparam logic [63:0] PES_STATUS_RESET  = 64'h0000_0000_0000_0000;
	localparam logic        PES_CONTROL_RESET = 1'h0;

	// ----------------------------------------------------------------
	// Error codes
	// ----------------------------------------------------------------
	localparam logic [3:0] PES_EC_NONE          = 4'h0;
	localparam logic [3:0] PES_EC_PART_SEL      = 4'h1;
	localparam logic [3:0] PES_EC_REQ_PARTITION_ID    = 4'h2;
	localparam logic [3:0] PES_EC_MON_CFG_ID    = 4'h3;
	localparam logic [3:0] PES_EC_REQ_PMG       = 4'h4;
	localparam logic [3:0] PES_EC_MON_RANGE     = 4'h5;
	localparam logic [3:0] PES_EC_INT_PARTITION_ID    = 4'h6;
	localparam logic [3:0] PES_EC_UNEXP_INTERN  = 4'h7;
	localparam logic [3:0] PES_EC_PS_NO_RIS     = 4'h8;
	localparam logic [3:0] PES_EC_PS_NO_CTRL    = 4'h9;
	localparam logic [3:0] PES_EC_MS_NO_RIS     = 4'hA;
	localparam logic [3:0] PES_EC_MS_NO_MON     = 4'hB;
	localparam logic [3:0] PES_EC_LAST_BASIC    = 4'h7;
	localparam logic [3:0] PES_EC_LAST_EXTENDED = 4'hB;

	// Error event reported by the checking logic around the block
	typedef struct packed {
		logic        valid;
		logic        secure;
		logic [3:0]  code;
		logic [3:0]  resource_instance_selector;
		logic [7:0]  perf_monitor_group;
		logic [15:0] index;
	} pes_event_t;

	// One register port access
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        secure;
		logic [11:0] offset;
		logic [63:0] wdata;
	} pes_access_t;

	// Storage for one status instance of the pair
	typedef struct packed {
		logic [3:0]  resource_instance_selector;
		logic        ovr;
		logic [3:0]  code;
		logic [7:0]  perf_monitor_group;
		logic [15:0] index;
	} pes_status_t;

endpackage

// ### src/pes_status_bank.sv
/*
 * Two-entry status store, one entry per security state, with registered read.
 * Assumes at most one write per entry per cycle, given by the owner.
 */
`timescale 1ns/100ps
module pes_status_bank
	import pes_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic [1:0]  wr_en,
	input  wire pes_status_t wr_data [2],
	input  wire logic        rd_sel,
	output pes_status_t      rd_data,
	output pes_status_t      cur [2]
);

	typedef struct packed {
		pes_status_t [1:0] ent;
		pes_status_t       rd;
	} pes_bank_state_t;

	pes_bank_state_t st;
	pes_bank_state_t next_st;

	// Entry update and read register
	always_comb
	begin
		next_st = st;
		for (int i = 0; i < 2; i++)
		begin
			if (wr_en[i])
			begin
				next_st.ent[i] = wr_data[i];
			end
		end
		next_st.rd = st.ent[rd_sel];
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign rd_data = st.rd;
	assign cur[0]  = st.ent[0];
	assign cur[1]  = st.ent[1];

endmodule

// ### test/pes_error_status_assertions.sv
/* Checker for pes_error_status: read answer timing, capture and irq causes.
   Assumes the block's default feature flags and one access per cycle. */
`timescale 1ns/100ps
module pes_error_status_assertions
	import pes_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rstn,
	input wire pes_access_t reg_acc,
	input wire pes_event_t  err_evt,
	input wire logic [63:0] reg_rdata,
	input wire logic        reg_rvalid,
	input wire logic        irq_secure,
	input wire logic        irq_nonsecure
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// Causes that may move an interrupt level
	wire logic wr_s = reg_acc.valid && reg_acc.write && reg_acc.secure;
	wire logic wr_n = reg_acc.valid && reg_acc.write && !reg_acc.secure;
	wire logic ev_s = err_evt.valid && err_evt.secure;
	wire logic ev_n = err_evt.valid && !err_evt.secure;
	// Secure error, then a Secure status read, then its answer
	sequence s_err_read;
		(ev_s && err_evt.code inside {[4'h1:4'hB]}) ##1 (reg_acc.valid && !reg_acc.write
		&& reg_acc.secure && reg_acc.offset == PES_OFS_STATUS) ##1 reg_rvalid;
	endsequence
	property p_rd_answer;
		(reg_acc.valid && !reg_acc.write) |=> reg_rvalid;
	endproperty
	property p_rv_cause;
		reg_rvalid |-> $past(reg_acc.valid) && !$past(reg_acc.write);
	endproperty
	property p_rsv_zero;
		reg_rvalid |-> reg_rdata[63:36] == 28'h0 && reg_rdata[30:28] == 3'h0;
	endproperty
	property p_cap_code;
		s_err_read |-> reg_rdata[27:24] == $past(err_evt.code, 2);
	endproperty
	property p_cap_pmg;
		s_err_read |-> reg_rdata[23:16] == ($past(err_evt.code, 2) inside {[4'h2:4'h4]}
			? $past(err_evt.perf_monitor_group, 2) : 8'h00);
	endproperty
	property p_cap_idx;
		s_err_read |-> reg_rdata[15:0] == $past(err_evt.index, 2);
	endproperty
	property p_irq_s_rise;
		$rose(irq_secure) |-> $past(ev_s) || $past(wr_s);
	endproperty
	property p_irq_n_rise;
		$rose(irq_nonsecure) |-> $past(ev_n) || $past(wr_n);
	endproperty
	property p_irq_s_fall;
		$fell(irq_secure) |-> $past(wr_s);
	endproperty
	property p_irq_n_fall;
		$fell(irq_nonsecure) |-> $past(wr_n);
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	a_rv_cause: assert property (p_rv_cause) else $error("answer without read");
	a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits set");
	a_cap_code: assert property (p_cap_code) else $error("code not recorded");
	a_cap_pmg: assert property (p_cap_pmg) else $error("group field wrong");
	a_cap_idx: assert property (p_cap_idx) else $error("index field wrong");
	a_irq_s_rise: assert property (p_irq_s_rise) else $error("secure irq rose");
	a_irq_n_rise: assert property (p_irq_n_rise) else $error("nonsecure irq rose");
	a_irq_s_fall: assert property (p_irq_s_fall) else $error("secure irq fell");
	a_irq_n_fall: assert property (p_irq_n_fall) else $error("nonsecure irq fell");
endmodule
bind pes_error_status pes_error_status_assertions u_chk (.core_clk(core_clk), .rstn(rstn),
	.reg_acc(reg_acc), .err_evt(err_evt), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.irq_secure(irq_secure), .irq_nonsecure(irq_nonsecure));

// ### test/pes_error_status_tb.sv
/* Self-checking bench for pes_error_status with a model of both instances.
   Assumes default feature flags and a free-running 40 MHz clock. */
`timescale 1ns/100ps
module pes_error_status_tb
	import pes_pkg::*;
;
	logic        core_clk;
	logic        rstn;
	pes_access_t reg_acc;
	pes_event_t  err_evt;
	logic [63:0] reg_rdata;
	logic        reg_rvalid;
	logic        irq_secure;
	logic        irq_nonsecure;
	logic [63:0] st [2];
	logic        en [2];
	logic [63:0] expq [$];
	logic [15:0] rnd;
	int          n_mismatch;
	int          n_checks;
	logic [1:0]  irq_exp;

	pes_error_status dut (.core_clk(core_clk), .rstn(rstn), .reg_acc(reg_acc),
		.err_evt(err_evt), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.irq_secure(irq_secure), .irq_nonsecure(irq_nonsecure));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// One clock of stimulus; read notes use the values before this edge
	task automatic cyc(input pes_access_t a, input pes_event_t e);
		@(posedge core_clk);
		reg_acc <= a;
		err_evt <= e;
		if (a.valid && !a.write)
			expq.push_back(a.offset == PES_OFS_STATUS ? st[a.secure] :
				a.offset == PES_OFS_CONTROL ? {63'h0, en[a.secure]} : 64'h0);
		if (a.valid && a.write && a.offset == PES_OFS_STATUS)
			st[a.secure] = a.wdata & 64'h0000_000F_8FFF_FFFF;
		if (a.valid && a.write && a.offset == PES_OFS_CONTROL)
			en[a.secure] = a.wdata[0];
		if (e.valid && e.code != 4'h0 && e.code <= PES_EC_LAST_EXTENDED)
			st[e.secure] = {28'h0, (e.code inside {4'h1, 4'h3, 4'h5, [4'h8:4'hB]}) ? e.resource_instance_selector : 4'h0,
				st[e.secure][27:24] != 4'h0, 3'h0, e.code,
				(e.code inside {[4'h2:4'h4]}) ? e.perf_monitor_group : 8'h00, e.index};
	endtask
	task automatic rd(input logic s, input logic [11:0] o);
		cyc('{1'b1, 1'b0, s, o, 64'h0}, '0);
	endtask
	task automatic wr(input logic s, input logic [11:0] o, input logic [63:0] d);
		cyc('{1'b1, 1'b1, s, o, d}, '0);
	endtask
	// Next value of the stimulus shift register
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic ev(input logic s, input logic [3:0] c, input logic r);
		rnd = lfsr_next(rnd);
		cyc(r ? pes_access_t'{1'b1, 1'b0, s, PES_OFS_STATUS, 64'h0} : pes_access_t'('0),
			'{1'b1, s, c, rnd[3:0], rnd[11:4], rnd});
	endtask
	// Idle long enough for a pending read answer before reset
	task automatic do_reset();
		repeat (2) cyc('0, '0);
		rstn <= 1'b0;
		st = '{64'h0, 64'h0};
		en = '{1'b0, 1'b0};
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
	endtask

	// ----------------------------------------------------------------
	// Clock, monitor and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// Compare answers with oldest note, irq levels with the model
	always @(negedge core_clk)
	begin
		if (reg_rvalid === 1'b1)
			check(reg_rdata, expq.size() > 0 ? expq.pop_front() : 64'hDEAD);
		// Design shows the model state of one cycle earlier
		if (rstn)
		begin
			check({63'h0, irq_secure}, {63'h0, irq_exp[1]});
			check({63'h0, irq_nonsecure}, {63'h0, irq_exp[0]});
		end
		irq_exp = {en[1] && st[1][27:24] != 4'h0, en[0] && st[0][27:24] != 4'h0};
	end
	initial
	begin
		#125000;
		n_mismatch++;
		$display("unexpected at %0t: run timed out", $time);
		test_done();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		rstn = 1'b0;
		reg_acc = '0;
		err_evt = '0;
		rnd = 16'h005F;
		n_mismatch = 0;
		n_checks = 0;
		do_reset();
		for (int s = 0; s < 2; s++)
		begin
			rd(s[0], PES_OFS_STATUS);
			rd(s[0], PES_OFS_CONTROL);
			wr(s[0], 12'h0F4, '1);
			rd(s[0], 12'h0F4);
		end
		// every code in both states, other instance untouched
		for (int c = 0; c < 16; c++)
			for (int s = 0; s < 2; s++)
			begin
				ev(s[0], c[3:0], 1'b0);
				rd(s[0], PES_OFS_STATUS);
				ev(!s[0], 4'hC, 1'b1);
			end
		wr(1'b1, PES_OFS_STATUS, 64'h0);
		wr(1'b1, PES_OFS_CONTROL, 64'h1);
		ev(1'b0, 4'h2, 1'b0);
		ev(1'b1, 4'h3, 1'b1);
		wr(1'b1, PES_OFS_CONTROL, 64'h0);
		wr(1'b1, PES_OFS_CONTROL, 64'h1);
		rd(1'b1, PES_OFS_CONTROL);
		wr(1'b1, PES_OFS_STATUS, 64'h0);
		wr(1'b0, PES_OFS_CONTROL, 64'h1);
		// software pattern, then a fresh error clears the flag
		wr(1'b0, PES_OFS_STATUS, 64'hFFFF_FFFF_F0FF_FFFF);
		rd(1'b0, PES_OFS_STATUS);
		ev(1'b0, 4'h6, 1'b1);
		ev(1'b0, 4'hB, 1'b1);
		rd(1'b0, PES_OFS_STATUS);
		// Reset in mid-run clears everything
		do_reset();
		rd(1'b0, PES_OFS_STATUS);
		rd(1'b1, PES_OFS_STATUS);
		repeat (3) cyc('0, '0);
		check(64'(expq.size()), 64'h0);
		test_done();
	end
endmodule
